// ==== pkg/hpcr_map.svh ====
// Register offsets, field positions, reset values and timing counts for the
// haptic playback configuration block. Assumes a 250 MHz aclk.
`ifndef HPCR_MAP_SVH
`define HPCR_MAP_SVH

// Printed register indices; byte address is four times the index
`define HPCR_IDX_LIB_CFG      8'h0d
`define HPCR_IDX_LIVE_DRIVE   8'h0e
`define HPCR_IDX_SLOT_FIRST   8'h0f
`define HPCR_IDX_LAST_SLOT    8'h16
`define HPCR_IDX_CONTROL      8'h20
`define HPCR_IDX_STATUS       8'h21

// Field positions
`define HPCR_INTERVAL_BIT     5
`define HPCR_LIB_SEL_POS      7
`define HPCR_DELAY_FLAG_POS   7
`define HPCR_FIRE_BIT         0
`define HPCR_LIVE_MODE_BIT    1

// Reset values
`define HPCR_LIB_CFG_RST      8'h00
`define HPCR_LIVE_DRIVE_RST   8'h7f
`define HPCR_SLOT_FIRST_RST   8'h01
`define HPCR_SLOT_OTHER_RST   8'h00

// Timing, times in microseconds
`define HPCR_CLK_MHZ          250
`define HPCR_TICK_SLOW_US     5000
`define HPCR_TICK_FAST_US     1000
`define HPCR_DELAY_UNIT_US    10000
`define HPCR_TICK_SLOW_CYC    (`HPCR_TICK_SLOW_US * `HPCR_CLK_MHZ)
`define HPCR_TICK_FAST_CYC    (`HPCR_TICK_FAST_US * `HPCR_CLK_MHZ)
`define HPCR_DELAY_UNIT_CYC   (`HPCR_DELAY_UNIT_US * `HPCR_CLK_MHZ)

`endif

// ==== pkg/hpcr_pkg.sv ====
// Types for the haptic playback configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package hpcr_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    HPCR_IDLE  = 4'b0001,
    HPCR_FETCH = 4'b0010,
    HPCR_PLAY  = 4'b0100,
    HPCR_PAUSE = 4'b1000
  } hpcr_seq_t;

  // Library choice
  typedef enum logic {
    HPCR_LIB_CLOSED_LRA = 1'b0,
    HPCR_LIB_OPEN_ERM   = 1'b1
  } hpcr_lib_t;

endpackage

// ==== src/hpcr_regs.sv ====
// Haptic playback configuration registers with AXI4-Lite slave, live drive path,
// library tick and the waveform sequencer that walks slots sequence_slot_first to 0x16.
// Assumes aclk at 250 MHz; the library engine reports end of effect on effect_done.
//
// Contract
// - Bit 7 of library config selects closed-loop LRA (0) or open-loop ERM (1).
// - Bit 5 picks library playback tick: clear is 5 ms, set is 1 ms.
// - Bits 1-0 scale library amplitude: full, three quarters, half, quarter.
// - Attenuation field is not applied in live playback mode.
// - Live mode and fired: drive the current live drive value to the load.
// - Host rewrites of live drive value apply at once, no retrigger.
// - Live drive value is an 8-bit two's-complement signed quantity.
// - Slot delay flag set: pause of value times 10 ms; clear: waveform index.
// - Fire bit stays set until done; host clear cancels; trigger sets it.
// - Sequence starts at slot sequence_slot_first, stops at zero id or after slot 0x16.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "hpcr_map.svh"

module hpcr_regs #(
  parameter int unsigned TICK_SLOW_CYC  = `HPCR_TICK_SLOW_CYC,
  parameter int unsigned TICK_FAST_CYC  = `HPCR_TICK_FAST_CYC,
  parameter int unsigned DELAY_UNIT_CYC = `HPCR_DELAY_UNIT_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [9:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [9:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_trigger,
  input  wire logic              effect_done,
  output hpcr_pkg::hpcr_lib_t    library_select,
  output logic                   library_tick,
  output logic                   effect_start,
  output logic [6:0]             effect_index,
  output logic [7:0]             drive_level,
  output logic                   drive_active,
  output logic                   sequence_busy
);
  import hpcr_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  lib_cfg_r;
  logic [7:0]  live_drive_value_r;
  logic [7:0]  slot_r [0:7];
  logic        fire_r;
  logic        live_mode_r;
  hpcr_seq_t   seq_r;
  logic [2:0]  slot_ptr_r;
  logic [31:0] pause_cnt_r;
  logic [31:0] tick_cnt_r;
  logic        trig_s1_r;
  logic        trig_s2_r;
  logic        trig_d_r;
  logic        done_s1_r;
  logic        done_s2_r;

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  aw_idx_r;
  logic [7:0]  w_data_r;
  logic        w_lane0_r;
  logic        wr_go;
  logic        wr_hit;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_bresp   = wr_hit ? 2'b00 : 2'b10;
  assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_hit = (aw_idx_r >= `HPCR_IDX_LIB_CFG && aw_idx_r <= `HPCR_IDX_LAST_SLOT)
               || aw_idx_r == `HPCR_IDX_CONTROL;

  // Capture address and data, then answer once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_idx_r     <= 8'h00;
      w_data_r     <= 8'h00;
      w_lane0_r    <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r  <= 1'b1;
        w_data_r  <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_en;
  assign wr_en = wr_go && w_lane0_r;

  // ----------------------------------------------------------------
  // Configuration and live drive registers
  // ----------------------------------------------------------------
  // Reserved bits of library config are plain storage, read back by the host but used by no logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lib_cfg_r          <= `HPCR_LIB_CFG_RST;
      live_drive_value_r <= `HPCR_LIVE_DRIVE_RST;
      live_mode_r        <= 1'b0;
    end else if (wr_en) begin
      if (aw_idx_r == `HPCR_IDX_LIB_CFG)
        lib_cfg_r <= w_data_r;
      if (aw_idx_r == `HPCR_IDX_LIVE_DRIVE)
        live_drive_value_r <= w_data_r;
      if (aw_idx_r == `HPCR_IDX_CONTROL)
        live_mode_r <= w_data_r[`HPCR_LIVE_MODE_BIT];
    end
  end

  // Eight sequencer slots in one loop
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_slot
      always_ff @(posedge aclk) begin
        if (!aresetn)
          slot_r[gi] <= (gi == 0) ? `HPCR_SLOT_FIRST_RST : `HPCR_SLOT_OTHER_RST;
        else if (wr_en && aw_idx_r == `HPCR_IDX_SLOT_FIRST + 8'(gi))
          slot_r[gi] <= w_data_r;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read channel, one cycle after address
  // ----------------------------------------------------------------
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic       rd_hit;
  assign rd_idx        = s_axi_araddr[9:2];
  assign s_axi_arready = !s_axi_rvalid;

  // Read multiplexer; status shows sequencer state
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    if (rd_idx == `HPCR_IDX_LIB_CFG)
      rd_byte = lib_cfg_r;
    else if (rd_idx == `HPCR_IDX_LIVE_DRIVE)
      rd_byte = live_drive_value_r;
    else if (rd_idx >= `HPCR_IDX_SLOT_FIRST && rd_idx <= `HPCR_IDX_LAST_SLOT)
      rd_byte = slot_r[3'(rd_idx - `HPCR_IDX_SLOT_FIRST)];
    else if (rd_idx == `HPCR_IDX_CONTROL)
      rd_byte = {6'b00_0000, live_mode_r, fire_r};
    else if (rd_idx == `HPCR_IDX_STATUS)
      rd_byte = {1'b0, slot_ptr_r, seq_r};
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r  <= 1'b0;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
    end else begin
      trig_s1_r <= ext_trigger;
      trig_s2_r <= trig_s1_r;
      trig_d_r  <= trig_s2_r;
      done_s1_r <= effect_done;
      done_s2_r <= done_s1_r;
    end
  end

  logic trig_rise;
  logic host_fire_wr;
  logic seq_end;
  assign trig_rise    = trig_s2_r && !trig_d_r;
  assign host_fire_wr = wr_en && aw_idx_r == `HPCR_IDX_CONTROL;

  // ----------------------------------------------------------------
  // Fire bit: set by write or trigger, cleared by host or completion
  // ----------------------------------------------------------------
  // Trigger set beats any clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      fire_r <= 1'b0;
    else if (trig_rise)
      fire_r <= 1'b1;
    else if (host_fire_wr)
      fire_r <= w_data_r[`HPCR_FIRE_BIT];
    else if (seq_end)
      fire_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [7:0] cur_slot;
  logic       last_slot;
  assign cur_slot  = slot_r[slot_ptr_r];
  assign last_slot = slot_ptr_r == 3'd7;
  assign seq_end   = !live_mode_r && ((seq_r == HPCR_FETCH && cur_slot[6:0] == 7'h00)
                  || ((seq_r == HPCR_PLAY && done_s2_r
                       || seq_r == HPCR_PAUSE && pause_cnt_r == 32'd0) && last_slot));

  // Walks slots from sequence_slot_first; clearing the fire bit aborts at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r        <= HPCR_IDLE;
      slot_ptr_r   <= 3'd0;
      pause_cnt_r  <= 32'd0;
      effect_start <= 1'b0;
      effect_index <= 7'h00;
    end else begin
      effect_start <= 1'b0;
      if (!fire_r || live_mode_r || seq_end) begin
        seq_r      <= HPCR_IDLE;
        slot_ptr_r <= 3'd0;
      end else begin
        case (seq_r)
          HPCR_IDLE: begin
            seq_r      <= HPCR_FETCH;
            slot_ptr_r <= 3'd0;
          end
          HPCR_FETCH: begin
            if (cur_slot[`HPCR_DELAY_FLAG_POS]) begin
              seq_r       <= HPCR_PAUSE;
              pause_cnt_r <= 32'(cur_slot[6:0]) * DELAY_UNIT_CYC - 32'd1;
            end else begin
              seq_r        <= HPCR_PLAY;
              effect_start <= 1'b1;
              effect_index <= cur_slot[6:0];
            end
          end
          HPCR_PLAY: begin
            if (done_s2_r) begin
              seq_r      <= HPCR_FETCH;
              slot_ptr_r <= slot_ptr_r + 3'd1;
            end
          end
          HPCR_PAUSE: begin
            if (pause_cnt_r == 32'd0) begin
              seq_r      <= HPCR_FETCH;
              slot_ptr_r <= slot_ptr_r + 3'd1;
            end else begin
              pause_cnt_r <= pause_cnt_r - 32'd1;
            end
          end
          default: seq_r <= HPCR_IDLE;
        endcase
      end
    end
  end

  assign sequence_busy  = seq_r != HPCR_IDLE;
  assign library_select = hpcr_lib_t'(lib_cfg_r[`HPCR_LIB_SEL_POS]);

  // ----------------------------------------------------------------
  // Library playback tick, 5 ms or 1 ms
  // ----------------------------------------------------------------
  logic [31:0] tick_period;
  assign tick_period = lib_cfg_r[`HPCR_INTERVAL_BIT] ? TICK_FAST_CYC : TICK_SLOW_CYC;

  always_ff @(posedge aclk) begin
    if (!aresetn || seq_r != HPCR_PLAY) begin
      tick_cnt_r   <= 32'd0;
      library_tick <= 1'b0;
    end else if (tick_cnt_r >= tick_period - 32'd1) begin
      tick_cnt_r   <= 32'd0;
      library_tick <= 1'b1;
    end else begin
      tick_cnt_r   <= tick_cnt_r + 32'd1;
      library_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Drive level: live value unscaled, library amplitude attenuated
  // ----------------------------------------------------------------
  // Library effect runs at full signed positive scale; shift keeps it cheap
  logic signed [9:0] full_amp;
  logic signed [9:0] lib_scaled;
  assign full_amp = 10'sd127;
  always_comb begin
    case (lib_cfg_r[1:0])
      2'd0:    lib_scaled = full_amp;
      2'd1:    lib_scaled = (full_amp * 10'sd3) >>> 2;
      2'd2:    lib_scaled = full_amp >>> 1;
      default: lib_scaled = full_amp >>> 2;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_level  <= 8'h00;
      drive_active <= 1'b0;
    end else if (live_mode_r && fire_r) begin
      drive_level  <= live_drive_value_r;
      drive_active <= 1'b1;
    end else if (seq_r == HPCR_PLAY) begin
      drive_level  <= lib_scaled[7:0];
      drive_active <= 1'b1;
    end else begin
      drive_level  <= 8'h00;
      drive_active <= 1'b0;
    end
  end

endmodule

// ==== test/hpcr_regs_props.sv ====
// Assertions on the haptic playback register block, bound to its top.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
module hpcr_regs_props #(
  parameter int unsigned TICK_SLOW_CYC  = 20,
  parameter int unsigned TICK_FAST_CYC  = 4,
  parameter int unsigned DELAY_UNIT_CYC = 10
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic [9:0]          s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [31:0]         s_axi_wdata,
  input wire logic [3:0]          s_axi_wstrb,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire hpcr_pkg::hpcr_lib_t library_select,
  input wire logic                library_tick,
  input wire logic                effect_start,
  input wire logic                sequence_busy
);
  import hpcr_pkg::*;
  logic [9:0]  wa_r;
  logic [7:0]  wd_r;
  logic        ws_r;
  int unsigned gap_r;
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // Capture the write in flight; the register itself is not visible here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa_r <= 10'h000;
      wd_r <= 8'h00;
      ws_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) ws_r <= s_axi_wstrb[0];
    end
  end
  // Cycles since last tick; saturates so a long idle never wraps
  always_ff @(posedge aclk) begin
    if (!aresetn) gap_r <= '1;
    else if (library_tick) gap_r <= 1;
    else if (gap_r != '1) gap_r <= gap_r + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while read data pending");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  AST_LIBSEL: assert property ($rose(s_axi_bvalid) && wa_r == 10'h034 && ws_r
    |-> library_select == hpcr_lib_t'(wd_r[7])) else $error("library choice wrong");
  AST_TICK_PULSE: assert property (library_tick |=> !library_tick)
    else $error("tick longer than one cycle");
  AST_TICK_GAP: assert property (library_tick |-> gap_r >= TICK_FAST_CYC)
    else $error("ticks closer than the fast period");
  AST_TICK_PLAY: assert property (library_tick |-> $past(sequence_busy))
    else $error("tick while sequencer idle");
  AST_START_BUSY: assert property (effect_start |-> sequence_busy ##1 !effect_start)
    else $error("effect start outside a sequence");
  cover property ($rose(s_axi_bvalid));
  cover property (effect_start);
  cover property (library_tick);
endmodule
bind hpcr_regs hpcr_regs_props #(
  .TICK_SLOW_CYC(TICK_SLOW_CYC), .TICK_FAST_CYC(TICK_FAST_CYC),
  .DELAY_UNIT_CYC(DELAY_UNIT_CYC)
) hpcr_regs_props_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .library_select(library_select), .library_tick(library_tick),
  .effect_start(effect_start), .sequence_busy(sequence_busy)
);

// ==== test/hpcr_host_model.sv ====
// Host controller model: an AXI4-Lite master driven by task calls.
// Assumes the slave answers in its own time; the bench timeout bounds waits.
`timescale 1ns/10ps
module hpcr_host_model (
  input  wire logic        aclk,
  output logic [9:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [9:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Quiet bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Write; may be issued at any time, live playback included
  task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    logic tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      // Sample mid-cycle: inputs only move just after rising edges
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask
  // Read one register
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the haptic playback register block.
// Assumes the host model drives the register bus; short timing parameters.
`timescale 1ns/10ps
module testbench;
  import hpcr_pkg::*;
  localparam int unsigned SLOW = 20;
  localparam int unsigned FAST = 4;
  localparam int unsigned UNIT = 10;
  logic        aclk, aresetn, ext_trigger, effect_done;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  hpcr_lib_t   library_select;
  logic        library_tick, effect_start, drive_active, sequence_busy;
  logic [6:0]  effect_index;
  logic [7:0]  drive_level;
  logic [7:0]  lv [3] = '{8'h80, 8'h05, 8'h7f};
  logic [7:0]  amp [4] = '{8'h7f, 8'h5f, 8'h3f, 8'h1f};
  int          fails = 0, n_compared = 0, cyc = 0, n;
  hpcr_regs #(.TICK_SLOW_CYC(SLOW), .TICK_FAST_CYC(FAST), .DELAY_UNIT_CYC(UNIT)) hpcr_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_trigger(ext_trigger), .effect_done(effect_done), .library_select(library_select),
    .library_tick(library_tick), .effect_start(effect_start), .effect_index(effect_index),
    .drive_level(drive_level), .drive_active(drive_active), .sequence_busy(sequence_busy));
  hpcr_host_model hpcr_host_model_inst (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // ------------------------------------------------------------
  // Clock, timeout and helpers
  // ------------------------------------------------------------
  always #2 aclk = ~aclk;
  // Whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
    hpcr_host_model_inst.rd(a, rv, rsp);
    chk("rdata", e, rv);
    chk("rresp", 32'(er), 32'(rsp));
  endtask
  task automatic wrc(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
    hpcr_host_model_inst.wr(a, d, rsp);
    chk("bresp", 32'(er), 32'(rsp));
  endtask
  // Bounded wait: 0 effect start, 1 tick, 2 sequencer idle
  task automatic wait_sig(input int k, output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c++;
    end while ((k == 0 ? effect_start : k == 1 ? library_tick : !sequence_busy) !== 1'b1
               && c < 200);
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ext_trigger = 1'b0;
    effect_done = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(10'h034, 32'h0000_0000, 2'b00);
    rdc(10'h038, 32'h0000_007f, 2'b00);
    rdc(10'h03c, 32'h0000_0001, 2'b00);
    rdc(10'h040, 32'h0000_0000, 2'b00);
    // Reserved bits stored but inert; both library choices
    for (int i = 0; i < 2; i++) begin
      wrc(10'h034, i ? 32'h0000_005c : 32'h0000_00dc, 2'b00);
      rdc(10'h034, i ? 32'h0000_005c : 32'h0000_00dc, 2'b00);
      chk("library_select", 32'(i == 0), 32'(library_select));
      chk("sequence_busy", 0, 32'(sequence_busy));
    end
    wrc(10'h3fc, 32'h0000_00aa, 2'b10);
    rdc(10'h3fc, 32'h0000_0000, 2'b10);
    // Live playback with quarter strength set, which must not apply
    wrc(10'h034, 32'h0000_0003, 2'b00);
    wrc(10'h080, 32'h0000_0003, 2'b00);
    foreach (lv[i]) begin
      wrc(10'h038, 32'(lv[i]), 2'b00);
      repeat (3) @(negedge aclk);
      chk("drive_level", 32'(lv[i]), 32'(drive_level));
      chk("drive_active", 1, 32'(drive_active));
    end
    wrc(10'h080, 32'h0000_0000, 2'b00);
    // Library effect, fast tick, half strength; slot two is zero
    wrc(10'h034, 32'h0000_0022, 2'b00);
    wrc(10'h03c, 32'h0000_0005, 2'b00);
    wrc(10'h080, 32'h0000_0001, 2'b00);
    wait_sig(0, n);
    chk("effect_index", 5, 32'(effect_index));
    repeat (2) @(negedge aclk);
    chk("drive_level", 32'h0000_003f, 32'(drive_level));
    wait_sig(1, n);
    wait_sig(1, n);
    chk("tick_gap", FAST, n);
    // Every attenuation code mid-effect, ending on the slow tick
    for (int g = 0; g < 4; g++) begin
      wrc(10'h034, 32'(g), 2'b00);
      repeat (2) @(negedge aclk);
      chk("drive_level", 32'(amp[g]), 32'(drive_level));
    end
    wait_sig(1, n);
    wait_sig(1, n);
    chk("tick_gap", SLOW, n);
    @(posedge aclk);
    effect_done <= 1'b1;
    repeat (3) @(posedge aclk);
    effect_done <= 1'b0;
    wait_sig(2, n);
    rdc(10'h080, 32'h0000_0000, 2'b00);
    // Pause of two units, then effect seven, cancelled by the host
    wrc(10'h03c, 32'h0000_0082, 2'b00);
    wrc(10'h040, 32'h0000_0007, 2'b00);
    wrc(10'h080, 32'h0000_0001, 2'b00);
    wait_sig(0, n);
    chk("pause_cycles", 1, 32'(n >= 2 * UNIT && n <= 2 * UNIT + 12));
    chk("effect_index", 7, 32'(effect_index));
    wrc(10'h080, 32'h0000_0000, 2'b00);
    repeat (3) @(negedge aclk);
    chk("sequence_busy", 0, 32'(sequence_busy));
    // External trigger sets the fire bit
    @(posedge aclk);
    ext_trigger <= 1'b1;
    repeat (3) @(posedge aclk);
    ext_trigger <= 1'b0;
    repeat (3) @(posedge aclk);
    rdc(10'h080, 32'h0000_0001, 2'b00);
    wrc(10'h080, 32'h0000_0000, 2'b00);
    tally_and_finish();
  end
endmodule
